// ==== flpf_pkg.sv ====
package flpf_pkg;

  // clock and timestamp timing
  localparam int unsigned FLPF_CLK_HZ = 20000000;
  localparam int unsigned FLPF_TICK_US = 200;
  localparam int unsigned FLPF_TICK_CYCLES = (FLPF_CLK_HZ / 1000000) * FLPF_TICK_US;
  localparam int FLPF_TICK_W = 13;
  localparam logic [FLPF_TICK_W-1:0] FLPF_TICK_LAST = FLPF_TICK_W'(FLPF_TICK_CYCLES - 1);

  // widths
  localparam int FLPF_TS_W = 41;
  localparam int FLPF_VAL_W = 16;
  localparam int FLPF_NCH = 4;
  localparam int FLPF_IDX_W = 7;

  // preamble byte layout
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_PTR = 7'h00;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_TS0 = 7'h01;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_TS_LAST = 7'h06;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_CH0 = 7'h07;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_VIN = 7'h13;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_CH1 = 7'h17;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_STAT = 7'h3B;
  localparam logic [FLPF_IDX_W-1:0] FLPF_B_LAST = 7'h46;
  localparam int FLPF_CH_BYTES = 12;
  localparam int FLPF_VIN_BYTES = 4;
  localparam int FLPF_STAT_BYTES = 3;

  // fifo shape
  localparam int FLPF_FIFO_DEPTH = 8;
  localparam int FLPF_FIFO_W = 9;

  // one channel of captured telemetry
  typedef struct packed {
    logic [FLPF_VAL_W-1:0] vout_peak;
    logic [FLPF_VAL_W-1:0] vout_min;
    logic [FLPF_VAL_W-1:0] temp_peak;
    logic [FLPF_VAL_W-1:0] temp_min;
    logic [FLPF_VAL_W-1:0] iout_peak;
    logic [FLPF_VAL_W-1:0] iout_min;
    logic [7:0] stat_vout;
    logic [7:0] stat_iout;
    logic [7:0] stat_temp;
  } flpf_chan_t;

  // whole snapshot presented at a fault
  typedef struct packed {
    logic [7:0] ptr;
    logic [FLPF_VAL_W-1:0] vin_peak;
    logic [FLPF_VAL_W-1:0] vin_min;
    flpf_chan_t [FLPF_NCH-1:0] ch;
  } flpf_snap_t;

  // stream word: byte plus last marker
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } flpf_beat_t;

  // framer states
  typedef enum logic [2:0] {
    FLPF_IDLE = 3'b001,
    FLPF_EMIT = 3'b010,
    FLPF_DONE = 3'b100
  } flpf_state_t;

endpackage

// ==== flpf_fifo.sv ====
module flpf_fifo
  import flpf_pkg::*;
#(
  parameter int WIDTH = FLPF_FIFO_W,
  parameter int DEPTH = FLPF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // fifo pointer state
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } flpf_fifo_st_t;

  flpf_fifo_st_t st_q, st_d;
  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic full, empty, push, pop;

  // honest full and empty from pointer compare
  assign empty = (st_q.wr == st_q.rd);
  assign full = (st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[st_q.rd[AW-1:0]];

  // pointer next state
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
  end

  // pointer register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[st_q.wr[AW-1:0]] <= in_data;
    end
  end

endmodule

// ==== flpf_framer.sv ====
// Behaviour
// - byte 0 holds fault pointer snapshot
// - bytes 1-6 timestamp, LSB first, bit40 last
// - timestamp ticks once per 200 us
// - byte 7 on: channel 0 six values
// - then input peak and minimum voltage
// - then channels one to three, to 58
// - bytes 59-70: three status per channel
// - preamble ends at byte 70
module flpf_framer
  import flpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fault capture
  input wire logic fault_capture,
  input wire flpf_snap_t snap_in,
  output logic busy,
  // running timestamp view
  output logic [FLPF_TS_W-1:0] shared_clock_timestamp,
  // byte stream to the block read
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // all framer state in one record
  typedef struct packed {
    flpf_state_t state;
    logic [FLPF_TICK_W-1:0] tick;
    logic [FLPF_TS_W-1:0] ts;
    logic [FLPF_TS_W-1:0] ts_snap;
    flpf_snap_t snap;
    logic [FLPF_IDX_W-1:0] idx;
  } flpf_st_t;

  flpf_st_t st_q, st_d;
  flpf_beat_t beat; // byte offered to the fifo
  logic fifo_in_ready; // fifo accepts a byte
  logic push; // byte enters the fifo
  logic [FLPF_FIFO_W-1:0] fifo_out; // fifo head

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // select low or high byte of a 16-bit value
  function automatic logic [7:0] flpf_half(input logic [FLPF_VAL_W-1:0] v, input logic hi);
    flpf_half = hi ? v[15:8] : v[7:0];
  endfunction

  // byte k (0..11) of one channel's telemetry block
  function automatic logic [7:0] flpf_chan_byte(input flpf_chan_t c, input logic [3:0] k);
    logic [FLPF_VAL_W-1:0] v;
    case (k[3:1])
      3'h0: v = c.vout_peak;
      3'h1: v = c.vout_min;
      3'h2: v = c.temp_peak;
      3'h3: v = c.temp_min;
      3'h4: v = c.iout_peak;
      default: v = c.iout_min;
    endcase
    flpf_chan_byte = flpf_half(v, k[0]);
  endfunction

  // byte k (0..2) of one channel's status triple
  function automatic logic [7:0] flpf_stat_byte(input flpf_chan_t c, input logic [1:0] k);
    case (k)
      2'h0: flpf_stat_byte = c.stat_vout;
      2'h1: flpf_stat_byte = c.stat_iout;
      default: flpf_stat_byte = c.stat_temp;
    endcase
  endfunction

  // preamble byte at a given index
  function automatic logic [7:0] flpf_byte_at(input flpf_st_t s, input logic [FLPF_IDX_W-1:0] i);
    logic [FLPF_IDX_W-1:0] off;
    logic [FLPF_TS_W+6:0] tsx;
    off = '0;
    tsx = {7'h00, s.ts_snap};
    flpf_byte_at = 8'h00;
    if (i == FLPF_B_PTR) begin
      flpf_byte_at = s.snap.ptr;
    end else if (i <= FLPF_B_TS_LAST) begin
      off = i - FLPF_B_TS0;
      flpf_byte_at = tsx[off[2:0]*8 +: 8];
    end else if (i < FLPF_B_VIN) begin
      off = i - FLPF_B_CH0;
      flpf_byte_at = flpf_chan_byte(s.snap.ch[0], off[3:0]);
    end else if (i < FLPF_B_CH1) begin
      off = i - FLPF_B_VIN;
      flpf_byte_at = flpf_half(off[1] ? s.snap.vin_min : s.snap.vin_peak, off[0]);
    end else if (i < FLPF_B_STAT) begin
      off = i - FLPF_B_CH1;
      flpf_byte_at = flpf_chan_byte(s.snap.ch[1 + off / FLPF_CH_BYTES],
                                    4'(off % FLPF_CH_BYTES));
    end else if (i <= FLPF_B_LAST) begin
      off = i - FLPF_B_STAT;
      flpf_byte_at = flpf_stat_byte(s.snap.ch[off / FLPF_STAT_BYTES],
                                    2'(off % FLPF_STAT_BYTES));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one fill of the record copy per cycle
  always_comb begin
    st_d = st_q;
    beat.data = flpf_byte_at(st_q, st_q.idx);
    beat.last = (st_q.idx == FLPF_B_LAST);
    push = (st_q.state == FLPF_EMIT) && fifo_in_ready;
    // free-running 200 us tick
    if (st_q.tick == FLPF_TICK_LAST) begin
      st_d.tick = '0;
      st_d.ts = st_q.ts + 1'b1;
    end else begin
      st_d.tick = st_q.tick + 1'b1;
    end
    case (st_q.state)
      FLPF_IDLE: begin
        // latch snapshot and timestamp at the fault
        if (fault_capture) begin
          st_d.snap = snap_in;
          st_d.ts_snap = st_q.ts;
          st_d.idx = FLPF_B_PTR;
          st_d.state = FLPF_EMIT;
        end
      end
      FLPF_EMIT: begin
        // advance only when the byte was taken, so none is skipped
        if (push) begin
          if (beat.last) begin
            st_d.state = FLPF_DONE;
          end else begin
            st_d.idx = st_q.idx + 1'b1;
          end
        end
      end
      FLPF_DONE: begin
        // loop bytes follow from elsewhere; decoding by pointer is the reader's
        st_d.state = FLPF_IDLE;
      end
      default: begin
        st_d.state = FLPF_IDLE;
      end
    endcase
  end

  // record register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.state <= FLPF_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer

  // fifo decouples the reader's pace from byte generation
  flpf_fifo #(
    .WIDTH(FLPF_FIFO_W),
    .DEPTH(FLPF_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(beat),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  // outputs
  assign out_data = fifo_out[7:0];
  assign out_last = fifo_out[8];
  assign busy = (st_q.state != FLPF_IDLE);
  assign shared_clock_timestamp = st_q.ts;

endmodule

// ==== flpf_chk.sv ====
module flpf_chk
  import flpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // capture side
  input wire logic fault_capture,
  input wire flpf_snap_t snap_in,
  input wire logic busy,
  input wire logic [FLPF_TS_W-1:0] shared_clock_timestamp,
  // stream side
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take, tk;
  logic [FLPF_TS_W-1:0] ts_q; // timestamp one cycle back
  logic [12:0] gap_q; // cycles since the last step
  logic seen_q; // one full step interval seen
  logic [6:0] n_q; // bytes taken in this record
  logic [7:0] ptr_q; // pointer latched at capture
  assign take = out_valid && out_ready;
  assign tk = shared_clock_timestamp != ts_q;
  // helper counters
  always_ff @(posedge ref_clk) begin
    ts_q <= shared_clock_timestamp;
    gap_q <= (!rst_n || tk) ? 13'h0000 : gap_q + 13'h0001;
    seen_q <= rst_n && (seen_q || tk);
    n_q <= !rst_n ? 7'h00 : (take ? (out_last ? 7'h00 : n_q + 7'h01) : n_q);
    if (fault_capture && !busy) begin
      ptr_q <= snap_in.ptr;
    end
  end
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable({out_data, out_last}))
    else $error("stalled byte changed");
  AST_ANS: assert property (fault_capture && !busy |-> ##2 out_valid)
    else $error("no byte two cycles after capture");
  AST_BUSY: assert property (fault_capture && !busy |=> busy [*2])
    else $error("busy not held after capture");
  AST_PTR: assert property (take && n_q == 7'h00 |-> out_data == ptr_q)
    else $error("first byte is not the pointer");
  AST_LAST: assert property (take |-> out_last == (n_q == FLPF_B_LAST))
    else $error("last marker on wrong byte");
  AST_END: assert property (take && out_last |-> ##[0:1] !busy)
    else $error("busy after final byte");
  AST_STEP: assert property (tk |-> shared_clock_timestamp == ts_q + 1'b1)
    else $error("timestamp step not one");
  AST_GAP: assert property (tk && seen_q |-> gap_q == FLPF_TICK_CYCLES - 1)
    else $error("timestamp step spacing wrong");
  cover property (take && out_last);
  cover property (fault_capture && busy);
  cover property (out_valid && !out_ready [*4]);
endmodule

bind flpf_framer flpf_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .fault_capture(fault_capture),
  .snap_in(snap_in), .busy(busy), .shared_clock_timestamp(shared_clock_timestamp),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last));

// ==== flpf_reader.sv ====
module flpf_reader (
  // clock
  input wire logic ref_clk,
  // pacing: 0 free, 1 random stalls, 2 hold off
  input wire logic [1:0] mode,
  // take strobe
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial out_ready = 1'b0;
  // bytes are taken in arrival order, record position counts up from byte 0
  always @(negedge ref_clk) begin
    out_ready <= mode == 2'h0 || (mode == 2'h1 && $urandom_range(3) != 0);
  end
endmodule

// ==== testbench.sv ====
module testbench
  import flpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault_capture = 1'b0;
  flpf_snap_t snap_in = '0;
  logic busy, out_valid, out_ready, out_last;
  logic [7:0] out_data;
  logic [FLPF_TS_W-1:0] shared_clock_timestamp;
  logic [1:0] mode = 2'h0; // reader pacing
  flpf_beat_t exp_q[$]; // expected bytes in order
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0; // cycles since reset release
  always #25 ref_clk = ~ref_clk;
  flpf_framer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .fault_capture(fault_capture),
    .snap_in(snap_in), .busy(busy), .shared_clock_timestamp(shared_clock_timestamp),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
  flpf_reader u_reader (.ref_clk(ref_clk), .mode(mode), .out_ready(out_ready));
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // cycle count and hang limit
  always @(posedge ref_clk) begin
    cyc <= rst_n ? cyc + 1 : 0;
    if (cyc > 12000) begin
      error_cnt++;
      conclude();
    end
  end
  // every byte taken is compared with the oldest note
  always @(posedge ref_clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      check({out_last, out_data}, exp_q.size() ? 9'(exp_q.pop_front()) : {1'bX, 8'hXX},
        "stream byte");
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic pb(input logic [7:0] b);
    exp_q.push_back('{last: 1'b0, data: b});
  endtask
  task automatic pw(input logic [15:0] v);
    pb(v[7:0]);
    pb(v[15:8]);
  endtask
  // random snapshot, capture pulse and the expected record
  task automatic capture();
    flpf_snap_t s;
    logic [15:0] w[6];
    logic [47:0] ts;
    for (int i = 0; i < $bits(s) / 8; i++) s[i*8 +: 8] = 8'($urandom);
    @(negedge ref_clk);
    ts = 48'(cyc / FLPF_TICK_CYCLES);
    snap_in = s;
    fault_capture = 1'b1;
    pb(s.ptr);
    for (int i = 0; i < 6; i++) pb(ts[i*8 +: 8]);
    for (int c = 0; c < FLPF_NCH; c++) begin
      w = '{s.ch[c].vout_peak, s.ch[c].vout_min, s.ch[c].temp_peak, s.ch[c].temp_min,
        s.ch[c].iout_peak, s.ch[c].iout_min};
      foreach (w[k]) pw(w[k]);
      if (c == 0) begin
        pw(s.vin_peak);
        pw(s.vin_min);
      end
    end
    for (int c = 0; c < FLPF_NCH; c++) begin
      pb(s.ch[c].stat_vout);
      pb(s.ch[c].stat_iout);
      pb(s.ch[c].stat_temp);
    end
    exp_q[$].last = 1'b1;
    @(negedge ref_clk);
    fault_capture = 1'b0;
  endtask
  // wait for the record to drain, then no byte may be owed
  task automatic finish_test(input string name);
    int n;
    n = 0;
    while ((busy !== 1'b0 || exp_q.size() != 0) && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check(9'(exp_q.size()), 9'h000, "bytes owed");
    // running stamp must sit at whole 200 us steps since reset release
    check(9'(shared_clock_timestamp), 9'(cyc / FLPF_TICK_CYCLES), "running stamp");
    $display("test %s done, errors %0d", name, error_cnt);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6EBE));
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    capture();
    finish_test("free reader");
    // fifo fills while held off; a second capture mid-record is refused
    mode = 2'h2;
    capture();
    repeat (5) @(negedge ref_clk);
    snap_in = ~snap_in;
    fault_capture = 1'b1;
    @(negedge ref_clk);
    fault_capture = 1'b0;
    repeat (20) @(negedge ref_clk);
    mode = 2'h1;
    finish_test("stalled reader");
    mode = 2'h0;
    // later record carries a stepped timestamp
    while (cyc < 2 * FLPF_TICK_CYCLES + 100) @(negedge ref_clk);
    capture();
    finish_test("later stamp");
    // reset in mid-record drops the record and restarts the stamp
    mode = 2'h2;
    capture();
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    exp_q.delete();
    check(9'({busy, out_valid}), 9'h000, "idle in reset");
    check(9'(shared_clock_timestamp), 9'h000, "stamp in reset");
    rst_n = 1'b1;
    mode = 2'h0;
    capture();
    finish_test("after reset");
    conclude();
  end
endmodule
